// ---- pfp_pkg.sv ----
// shared constants for the program flash size limit and parallel programming
package pfp_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_PROGRAM_SIZE_LIMIT = 8'hC2;
    localparam logic [7:0]  IDX_TIMED_ACCESS       = 8'hC7;
    localparam logic [11:0] ADDR_PROGRAM_SIZE_LIMIT =
        {2'h0, IDX_PROGRAM_SIZE_LIMIT, 2'h0};
    localparam logic [11:0] ADDR_TIMED_ACCESS =
        {2'h0, IDX_TIMED_ACCESS, 2'h0};

    // size-select field
    localparam int          SIZE_SEL_LSB   = 0;
    localparam int          SIZE_SEL_W     = 3;
    localparam logic [2:0]  SIZE_SEL_RESET = 3'h5;
    localparam logic [2:0]  SIZE_SEL_FULL  = 3'h5;
    localparam logic [16:0] SIZE_BYTES_FULL = 17'h04000;
    localparam logic [16:0] SIZE_BYTES_UNIT = 17'h00200;

    // timed-access key sequence and open window
    localparam logic [7:0]  TA_KEY_FIRST  = 8'hAA;
    localparam logic [7:0]  TA_KEY_SECOND = 8'h55;
    localparam logic [3:0]  TA_WINDOW_CYC = 4'h8;

    // flash geometry
    localparam int          FLASH_AW    = 14;
    localparam int          FLASH_DW    = 8;
    localparam int          FLASH_WORDS = 16384;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    // clock
    localparam int          CLOCK_PERIOD_NS = 5;

    // instruction select codes on {p2_7, p2_6, p3_7, p3_6}
    localparam logic [3:0]  CMD_ERASE       = 4'h1;
    localparam logic [3:0]  CMD_PROG_CODE   = 4'h2;
    localparam logic [3:0]  CMD_VERIFY_CODE = 4'h3;
    localparam logic [3:0]  CMD_PROG_LOCK   = 4'h4;
    localparam logic [3:0]  CMD_VERIFY_LOCK = 4'h5;
    localparam logic [3:0]  CMD_READ_SIG    = 4'h6;
    localparam logic [3:0]  CMD_PROG_OPT    = 4'h7;
    localparam logic [3:0]  CMD_VERIFY_OPT  = 4'h8;

    // signature locations
    localparam logic [13:0] SIG_ADDR_0 = 14'h0030;
    localparam logic [13:0] SIG_ADDR_1 = 14'h0031;
    localparam logic [13:0] SIG_ADDR_2 = 14'h0060;

    // reset values of security and option state
    localparam logic [2:0]  LOCK_RESET = 3'h0;
    localparam int          READBACK_LOCK_POS = 1;
    localparam logic [7:0]  OPT_RESET  = 8'hFF;
    localparam logic        BANK_SELECT_RESET = 1'b0;

    typedef enum logic [2:0] {
        PFP_ST_IDLE  = 3'b001,
        PFP_ST_ERASE = 3'b010,
        PFP_ST_PROG  = 3'b100
    } pfp_state_t;

endpackage

// ---- pfp_flash_array.sv ----
// program flash storage array with one write and one read port
`timescale 1ns/100ps
module pfp_flash_array (
    input  wire logic                           clock,
    input  wire logic                           rstn,
    input  wire logic                           wr_en,
    input  wire logic [pfp_pkg::FLASH_AW-1:0]   wr_addr,
    input  wire logic [pfp_pkg::FLASH_DW-1:0]   wr_data,
    input  wire logic [pfp_pkg::FLASH_AW-1:0]   rd_addr,
    output logic      [pfp_pkg::FLASH_DW-1:0]   rd_data_q
);

    // contents are undefined until the first mass erase
    logic [pfp_pkg::FLASH_DW-1:0] mem [pfp_pkg::FLASH_WORDS];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule

// ---- pfp_top.sv ----
// program size limit register and parallel programming port of program flash
//
// Function
// - reset limit covers full 16kB internal
// - fetches below limit go internal while external_access_select is high, outside programming mode
// - size-select field shrinks internal program size
// - size-select written only via timed access
// - lowered limit takes next fetch externally
// - mass erase clears flash, security, bank select
// - bank select reset only by erase; rstn also loads BANK_SELECT_RESET here
// - readback allowed while readback lock unprogrammed
// - lock bits readable in programming mode
// - one instruction reads signature locations
// - separate option register instructions
// - reset high, access high, strobe low enters
// - four pins select the instruction
// - verify drives stored data on port 0
// - one pulse starts each erase or program
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module pfp_top #(
    parameter int ERASE_WORDS = 16384
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_q,
    output logic             pready_q,
    output logic             pslverr_q,
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_internal_q,
    output logic      [7:0]  fetch_data_q,
    input  wire logic        reset_pin,
    input  wire logic        external_access_select,
    input  wire logic        program_store_strobe,
    input  wire logic        latch_program_pulse,
    input  wire logic        p2_6,
    input  wire logic        p2_7,
    input  wire logic        p3_6,
    input  wire logic        p3_7,
    input  wire logic [7:0]  p1_in,
    input  wire logic [5:0]  p2_in,
    input  wire logic [7:0]  p0_in,
    output logic      [7:0]  p0_out_q,
    output logic             p0_oe_n_q,
    output logic             prog_mode_q,
    output logic             prog_busy_q,
    output logic             bank_select_q
);

    localparam int PIN_W = 30;

    // byte count of internal program space for a size-select value
    function automatic logic [16:0] size_bytes(input logic [2:0] sel);
        logic [16:0] bytes;
        bytes = '0;
        if (sel >= pfp_pkg::SIZE_SEL_FULL) begin
            bytes = pfp_pkg::SIZE_BYTES_FULL;
        end else if (sel != 3'h0) begin
            bytes = 17'(pfp_pkg::SIZE_BYTES_UNIT << sel);
        end
        return bytes;
    endfunction

    // pin synchronisers; pulse bit resets to its idle high level
    logic [PIN_W-1:0] pins_s1_q;
    logic [PIN_W-1:0] pins_s2_q;
    logic             pulse_s3_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pins_s1_q <= 30'h04000000;
            pins_s2_q <= 30'h04000000;
        end else begin
            pins_s1_q <= {reset_pin, external_access_select,
                          program_store_strobe, latch_program_pulse,
                          p2_7, p2_6, p3_7, p3_6, p2_in, p1_in, p0_in};
            pins_s2_q <= pins_s1_q;
        end
    end

    logic        rst_s;
    logic        ea_s;
    logic        strobe_s;
    logic        pulse_s;
    logic [3:0]  cmd_s;
    logic [13:0] paddr_s;
    logic [7:0]  pdata_s;
    assign rst_s    = pins_s2_q[29];
    assign ea_s     = pins_s2_q[28];
    assign strobe_s = pins_s2_q[27];
    assign pulse_s  = pins_s2_q[26];
    assign cmd_s    = pins_s2_q[25:22];
    assign paddr_s  = pins_s2_q[21:8];
    assign pdata_s  = pins_s2_q[7:0];
    logic prog_mode;
    logic pulse_fall;
    assign prog_mode  = rst_s & ea_s & ~strobe_s;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pulse_s3_q <= 1'b1;
        end else begin
            pulse_s3_q <= pulse_s;
        end
    end

    // pulse is active low; the falling edge starts exactly one operation
    assign pulse_fall = pulse_s3_q & ~pulse_s;

    // apb slave
    logic        apb_setup;
    logic        apb_access;
    logic        hit_size;
    logic        hit_ta;
    logic        bad_addr;
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable & pready_q;
    assign hit_size   = (paddr == pfp_pkg::ADDR_PROGRAM_SIZE_LIMIT);
    assign hit_ta     = (paddr == pfp_pkg::ADDR_TIMED_ACCESS);
    assign bad_addr   = ~hit_size & ~hit_ta;
    logic [2:0]  size_sel_q;
    logic [1:0]  ta_stage_q;
    logic [3:0]  ta_count_q;
    logic        ta_open;
    assign ta_open = (ta_stage_q == 2'h2) && (ta_count_q != 4'h0);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q <= apb_setup;
            if (apb_setup) begin
                pslverr_q <= bad_addr;
                if (hit_size) begin
                    prdata_q <= {29'h0, size_sel_q};
                end else if (hit_ta) begin
                    prdata_q <= {31'h0, ta_open};
                end else begin
                    prdata_q <= '0;
                end
            end else if (apb_access) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // timed access: key pair opens a short window for one protected write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ta_stage_q <= 2'h0;
            ta_count_q <= 4'h0;
        end else if (apb_access && pwrite && hit_ta) begin
            if (pwdata[7:0] == pfp_pkg::TA_KEY_FIRST) begin
                ta_stage_q <= 2'h1;
                ta_count_q <= 4'h0;
            end else if (pwdata[7:0] == pfp_pkg::TA_KEY_SECOND &&
                         ta_stage_q == 2'h1) begin
                ta_stage_q <= 2'h2;
                ta_count_q <= pfp_pkg::TA_WINDOW_CYC;
            end else begin
                ta_stage_q <= 2'h0;
                ta_count_q <= 4'h0;
            end
        end else if (apb_access && pwrite && hit_size) begin
            ta_stage_q <= 2'h0;
            ta_count_q <= 4'h0;
        end else if (ta_stage_q == 2'h2) begin
            if (ta_count_q == 4'h0) begin
                ta_stage_q <= 2'h0;
            end else begin
                ta_count_q <= ta_count_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            size_sel_q <= pfp_pkg::SIZE_SEL_RESET;
        end else if (apb_access && pwrite && hit_size && ta_open) begin
            size_sel_q <= pwdata[pfp_pkg::SIZE_SEL_LSB +:
                                 pfp_pkg::SIZE_SEL_W];
        end
    end

    // fetch routing uses the live limit, so a lowered limit applies to
    // the very next fetch; software must run from a region that stays put
    logic [16:0] limit_bytes;
    logic        fetch_in_range;

    assign limit_bytes    = size_bytes(size_sel_q);
    assign fetch_in_range = ({1'b0, fetch_addr} < limit_bytes);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fetch_internal_q <= 1'b0;
        end else begin
            fetch_internal_q <= fetch_req & ea_s & ~prog_mode &
                                fetch_in_range;
        end
    end

    // parallel programming engine
    pfp_pkg::pfp_state_t state_q;
    logic [13:0] erase_cnt_q;
    logic [13:0] prog_addr_q;
    logic [7:0]  prog_data_q;
    logic [2:0]  lock_q;
    logic [7:0]  opt_q;
    logic        erase_last;

    assign erase_last = (erase_cnt_q == 14'(ERASE_WORDS - 1));

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q     <= pfp_pkg::PFP_ST_IDLE;
            erase_cnt_q <= '0;
            prog_addr_q <= '0;
            prog_data_q <= '0;
        end else begin
            case (state_q)
                pfp_pkg::PFP_ST_IDLE: begin
                    erase_cnt_q <= '0;
                    if (prog_mode && pulse_fall) begin
                        prog_addr_q <= paddr_s;
                        prog_data_q <= pdata_s;
                        if (cmd_s == pfp_pkg::CMD_ERASE) begin
                            state_q <= pfp_pkg::PFP_ST_ERASE;
                        end else if (cmd_s == pfp_pkg::CMD_PROG_CODE) begin
                            state_q <= pfp_pkg::PFP_ST_PROG;
                        end
                    end
                end
                pfp_pkg::PFP_ST_ERASE: begin
                    erase_cnt_q <= erase_cnt_q + 14'h1;
                    if (erase_last) begin
                        state_q <= pfp_pkg::PFP_ST_IDLE;
                    end
                end
                pfp_pkg::PFP_ST_PROG: begin
                    state_q <= pfp_pkg::PFP_ST_IDLE;
                end
                default: begin
                    state_q <= pfp_pkg::PFP_ST_IDLE;
                end
            endcase
        end
    end

    // security and option state; pulses on other codes are ignored
    logic start_idle;

    assign start_idle = (state_q == pfp_pkg::PFP_ST_IDLE) && prog_mode &&
                        pulse_fall;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_q        <= pfp_pkg::LOCK_RESET;
            opt_q         <= pfp_pkg::OPT_RESET;
            bank_select_q <= pfp_pkg::BANK_SELECT_RESET;
        end else if (start_idle && cmd_s == pfp_pkg::CMD_ERASE) begin
            lock_q        <= pfp_pkg::LOCK_RESET;
            opt_q         <= pfp_pkg::OPT_RESET;
            bank_select_q <= pfp_pkg::BANK_SELECT_RESET;
        end else if (start_idle && cmd_s == pfp_pkg::CMD_PROG_LOCK) begin
            // lock bits only ever get programmed, never cleared here
            lock_q <= lock_q | pdata_s[2:0];
        end else if (start_idle && cmd_s == pfp_pkg::CMD_PROG_OPT) begin
            opt_q <= pdata_s;
        end
    end

    // flash array access
    logic        fl_wr_en;
    logic [13:0] fl_wr_addr;
    logic [7:0]  fl_wr_data;
    logic [13:0] fl_rd_addr;
    logic [7:0]  fl_rd_data;

    assign fl_wr_en   = (state_q == pfp_pkg::PFP_ST_ERASE) ||
                        (state_q == pfp_pkg::PFP_ST_PROG);
    assign fl_wr_addr = (state_q == pfp_pkg::PFP_ST_ERASE) ? erase_cnt_q :
                        prog_addr_q;
    assign fl_wr_data = (state_q == pfp_pkg::PFP_ST_ERASE) ?
                        pfp_pkg::ERASED_BYTE : prog_data_q;
    assign fl_rd_addr = prog_mode ? paddr_s : fetch_addr[13:0];

    pfp_flash_array u_flash (
        .clock     (clock),
        .rstn      (rstn),
        .wr_en     (fl_wr_en),
        .wr_addr   (fl_wr_addr),
        .wr_data   (fl_wr_data),
        .rd_addr   (fl_rd_addr),
        .rd_data_q (fl_rd_data)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fetch_data_q <= '0;
        end else begin
            fetch_data_q <= fl_rd_data;
        end
    end

    localparam logic [7:0] SIG_BYTE_0 = 8'hA5; // arbitrary value
    localparam logic [7:0] SIG_BYTE_1 = 8'h5A; // arbitrary value
    localparam logic [7:0] SIG_BYTE_2 = 8'h3C; // arbitrary value
    logic [7:0] sig_byte;
    always_comb begin
        sig_byte = 8'h00;
        if (paddr_s == pfp_pkg::SIG_ADDR_0) begin
            sig_byte = SIG_BYTE_0;
        end else if (paddr_s == pfp_pkg::SIG_ADDR_1) begin
            sig_byte = SIG_BYTE_1;
        end else if (paddr_s == pfp_pkg::SIG_ADDR_2) begin
            sig_byte = SIG_BYTE_2;
        end
    end

    // port 0 driver for verify-type codes
    logic       verify_cmd;
    logic [7:0] verify_data;

    always_comb begin
        verify_cmd  = 1'b0;
        verify_data = 8'h00;
        if (cmd_s == pfp_pkg::CMD_VERIFY_CODE) begin
            verify_cmd = 1'b1;
            // parts with the readback lock bit programmed read back as all ones
            verify_data = lock_q[pfp_pkg::READBACK_LOCK_POS] ?
                          8'hFF : fl_rd_data;
        end else if (cmd_s == pfp_pkg::CMD_VERIFY_LOCK) begin
            verify_cmd  = 1'b1;
            verify_data = {5'h00, lock_q};
        end else if (cmd_s == pfp_pkg::CMD_READ_SIG) begin
            verify_cmd  = 1'b1;
            verify_data = sig_byte;
        end else if (cmd_s == pfp_pkg::CMD_VERIFY_OPT) begin
            verify_cmd  = 1'b1;
            verify_data = opt_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            p0_out_q    <= '0;
            p0_oe_n_q   <= 1'b1;
            prog_mode_q <= 1'b0;
            prog_busy_q <= 1'b0;
        end else begin
            p0_out_q    <= verify_data;
            p0_oe_n_q   <= ~(prog_mode & verify_cmd);
            prog_mode_q <= prog_mode;
            prog_busy_q <= (state_q != pfp_pkg::PFP_ST_IDLE);
        end
    end

endmodule

// ---- pfp_assertions.sv ----
// concurrent checks on the size limit and programming port
`timescale 1ns/100ps
module pfp_assertions #(
    parameter int ERASE_WORDS = 16384
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready_q,
    input wire logic        pslverr_q,
    input wire logic [15:0] fetch_addr,
    input wire logic        fetch_internal_q,
    input wire logic        p0_oe_n_q,
    input wire logic        prog_mode_q,
    input wire logic        prog_busy_q,
    input wire logic        bank_select_q
);
    logic [15:0] busy_cnt_q;
    // counter, as an erase outlasts any short repetition
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_q <= 16'h0000;
        end else if (prog_busy_q) begin
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        end else begin
            busy_cnt_q <= 16'h0000;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    property p_apb_wait;
        psel && !penable |=> pready_q ##1 !pready_q;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb wait");
    property p_apb_ready;
        pready_q |-> psel && penable;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready");
    property p_apb_err;
        pready_q |-> pslverr_q == (paddr != 12'h308 && paddr != 12'h31C);
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("apb error");
    property p_fetch_limit;
        fetch_internal_q |-> $past(fetch_addr) < 16'h4000;
    endproperty
    a_fetch_limit: assert property (p_fetch_limit)
        else $error("fetch above limit");
    property p_mode_fetch;
        prog_mode_q && $past(prog_mode_q) |-> !fetch_internal_q;
    endproperty
    a_mode_fetch: assert property (p_mode_fetch)
        else $error("fetch in programming mode");
    property p_port_drive;
        !p0_oe_n_q |-> prog_mode_q;
    endproperty
    a_port_drive: assert property (p_port_drive)
        else $error("port driven outside mode");
    property p_busy_start;
        $rose(prog_busy_q) |-> $past(prog_mode_q);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy outside mode");
    property p_busy_len;
        prog_busy_q |-> busy_cnt_q <= ERASE_WORDS + 4;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy too long");
    property p_bank;
        !bank_select_q;
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select changed");
endmodule
bind pfp_top pfp_assertions #(.ERASE_WORDS(ERASE_WORDS)) chk_u (
    .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .fetch_addr(fetch_addr), .fetch_internal_q(fetch_internal_q),
    .p0_oe_n_q(p0_oe_n_q), .prog_mode_q(prog_mode_q),
    .prog_busy_q(prog_busy_q), .bank_select_q(bank_select_q)
);

// ---- pfp_programmer.sv ----
// programmer model for the parallel programming port
`timescale 1ns/100ps
module pfp_programmer (
    input  wire logic        clock,
    input  wire logic        prog_busy_q,
    input  wire logic [7:0]  p0_out_q,
    input  wire logic        p0_oe_n_q,
    output logic             reset_pin,
    output logic             external_access_select,
    output logic             program_store_strobe,
    output logic             latch_program_pulse,
    output logic      [3:0]  cmd,
    output logic      [13:0] addr,
    output logic      [7:0]  p0_in
);
    initial begin
        reset_pin = 1'b0;
        external_access_select = 1'b1;
        program_store_strobe = 1'b1;
        latch_program_pulse = 1'b1;
        cmd = 4'h0;
        addr = 14'h0000;
        p0_in = 8'h5A;
    end
    task automatic set_mode(input logic on);
        reset_pin <= on;
        program_store_strobe <= !on;
        repeat (6) @(posedge clock);
    endtask
    // inputs held through pulse and busy time
    task automatic pulse(input logic [3:0] c, input logic [13:0] a,
                         input logic [7:0] d, output int n);
        cmd <= c;
        addr <= a;
        p0_in <= d;
        repeat (4) @(posedge clock);
        latch_program_pulse <= 1'b0;
        repeat (3) @(posedge clock);
        latch_program_pulse <= 1'b1;
        n = 0;
        for (int k = 0; k < 5000 && (k < 8 || prog_busy_q); k++) begin
            @(posedge clock);
            if (prog_busy_q === 1'b1) n++;
        end
        cmd <= 4'h0;
        p0_in <= ~d;
    endtask
    // released port shows inverted data, never a stale copy
    task automatic read_port(input logic [3:0] c, input logic [13:0] a,
                             output logic [8:0] r);
        cmd <= c;
        addr <= a;
        p0_in <= ~p0_in;
        repeat (8) @(posedge clock);
        r = {p0_oe_n_q, p0_out_q};
        cmd <= 4'h0;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ---- pfp_top_test.sv ----
// self-checking bench for the size limit and programming port
`timescale 1ns/100ps
module pfp_top_test;
    localparam int EW = 64;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        fetch_req = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, fetch_internal_q;
    logic [7:0]  p0_out_q, p0_in, fetch_data_q;
    logic        p0_oe_n_q, prog_mode_q, prog_busy_q, bank_select_q;
    logic        reset_pin, ea, strobe, pulse_n;
    logic [3:0]  cmd;
    logic [13:0] pa;
    logic [31:0] seed, r;
    logic        e;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    always #2.5 clock = ~clock; // runs through programming
    pfp_top #(.ERASE_WORDS(EW)) dut_u (
        .clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_internal_q(fetch_internal_q), .fetch_data_q(fetch_data_q),
        .reset_pin(reset_pin), .external_access_select(ea),
        .program_store_strobe(strobe), .latch_program_pulse(pulse_n),
        .p2_6(cmd[2]), .p2_7(cmd[3]), .p3_6(cmd[0]), .p3_7(cmd[1]),
        .p1_in(pa[7:0]), .p2_in(pa[13:8]), .p0_in(p0_in),
        .p0_out_q(p0_out_q), .p0_oe_n_q(p0_oe_n_q),
        .prog_mode_q(prog_mode_q), .prog_busy_q(prog_busy_q),
        .bank_select_q(bank_select_q)
    );
    pfp_programmer prog_u (
        .clock(clock), .prog_busy_q(prog_busy_q), .p0_out_q(p0_out_q),
        .p0_oe_n_q(p0_oe_n_q), .reset_pin(reset_pin),
        .external_access_select(ea), .program_store_strobe(strobe),
        .latch_program_pulse(pulse_n), .cmd(cmd), .addr(pa), .p0_in(p0_in)
    );
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready_q !== 1'b1);
        r = prdata_q;
        e = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic unlock_size(input logic [2:0] s);
        apb(1'b1, 12'h31C, 32'h000000AA);
        apb(1'b1, 12'h31C, 32'h00000055);
        apb(1'b1, 12'h308, {29'h0, s});
    endtask
    task automatic get_size(input logic [31:0] exp);
        apb(1'b0, 12'h308, 32'h0);
        cmp(r, exp, "size");
    endtask
    task automatic fetch_chk(input logic [15:0] a, input logic exp);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        repeat (2) @(posedge clock);
        cmp({31'h0, fetch_internal_q}, {31'h0, exp}, "fetch");
    endtask
    task automatic chk_port(input logic [3:0] c, input logic [13:0] a,
                            input logic [8:0] exp);
        logic [8:0] q;
        prog_u.read_port(c, a, q);
        cmp({23'h0, q}, {23'h0, exp}, "port");
    endtask
    function automatic logic [16:0] lim(input logic [2:0] s);
        if (s == 3'h0) return 17'h00000;
        if (s >= 3'h5) return 17'h04000;
        return 17'h00400 << (s - 3'h1);
    endfunction
    task automatic erase_chk();
        int n;
        prog_u.pulse(pfp_pkg::CMD_ERASE, 14'h0000, 8'h00, n);
        cmp(32'(n >= EW && n <= EW + 2), 32'h1, "erase");
        cmp({31'h0, bank_select_q}, 32'h0, "bank");
        chk_port(pfp_pkg::CMD_VERIFY_LOCK, 14'h0000, 9'h000);
        chk_port(pfp_pkg::CMD_VERIFY_OPT, 14'h0000, 9'h0FF);
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        logic [16:0] l;
        logic [13:0] pad;
        logic [7:0]  d;
        int          n;
        seed = 32'h60ADB47E;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        get_size(32'h5);
        fetch_chk(16'h3FFF, 1'b1);
        fetch_chk(16'h4000, 1'b0);
        apb(1'b1, 12'h308, 32'h2);
        get_size(32'h5);
        apb(1'b0, 12'h300, 32'h0);
        cmp({31'h0, e}, 32'h1, "unmapped");
        apb(1'b1, 12'h31C, 32'h000000AA);
        apb(1'b1, 12'h31C, 32'h00000055);
        apb(1'b0, 12'h31C, 32'h0);
        cmp(r, 32'h1, "window");
        repeat (12) @(posedge clock);
        apb(1'b1, 12'h308, 32'h1);
        get_size(32'h5);
        for (int s = 7; s >= 0; s--) begin
            unlock_size(s[2:0]);
            get_size(s);
            l = lim(s[2:0]);
            fetch_chk(16'h3000, l > 17'h03000);
            fetch_chk(l[15:0], 1'b0);
            if (l != 17'h0) fetch_chk(l[15:0] - 16'h1, 1'b1);
            fetch_addr <= 16'($random(seed));
            @(posedge clock);
            fetch_chk(fetch_addr, {1'b0, fetch_addr} < l);
        end
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        get_size(32'h5);
        prog_u.set_mode(1'b1);
        cmp({31'h0, prog_mode_q}, 32'h1, "mode");
        erase_chk();
        for (int i = 0; i < 4; i++) begin
            pad = 14'(i * 16) | 14'($random(seed) & 15);
            d = 8'($random(seed));
            prog_u.pulse(pfp_pkg::CMD_PROG_CODE, pad, d, n);
            cmp(32'(n > 0), 32'h1, "busy");
            chk_port(pfp_pkg::CMD_VERIFY_CODE, pad, {1'b0, d});
        end
        chk_port(pfp_pkg::CMD_READ_SIG, 14'h0030, 9'h0A5);
        chk_port(pfp_pkg::CMD_READ_SIG, 14'h0031, 9'h05A);
        chk_port(pfp_pkg::CMD_READ_SIG, 14'h0060, 9'h03C);
        prog_u.pulse(pfp_pkg::CMD_PROG_LOCK, 14'h0000, 8'h01, n);
        chk_port(pfp_pkg::CMD_VERIFY_LOCK, 14'h0000, 9'h001);
        chk_port(pfp_pkg::CMD_VERIFY_CODE, pad, {1'b0, d});
        prog_u.pulse(pfp_pkg::CMD_PROG_LOCK, 14'h0000, 8'h02, n);
        chk_port(pfp_pkg::CMD_VERIFY_LOCK, 14'h0000, 9'h003);
        chk_port(pfp_pkg::CMD_VERIFY_CODE, pad, 9'h0FF);
        erase_chk();
        chk_port(pfp_pkg::CMD_VERIFY_CODE, pad, 9'h0FF);
        prog_u.set_mode(1'b0);
        cmp({31'h0, prog_mode_q}, 32'h0, "mode exit");
        fetch_chk({2'h0, pad}, 1'b1);
        @(posedge clock);
        cmp({24'h0, fetch_data_q}, 32'hFF, "fetch data");
        print_verdict();
    end
endmodule
